// >>> src/bdi_pkg.sv
// Constants shared by the bus decode and interrupt vector block
package bdi_pkg;
    localparam int ADDR_W        = 18;
    localparam int DEC_LO        = 3;
    localparam int DEC_HI        = 12;
    localparam int DEC_N         = 10;
    localparam int SEL_W         = 3;
    localparam int VEC_LO        = 3;
    localparam int VEC_HI        = 8;
    localparam int VEC_N         = 6;
    localparam int VEC_W         = 9;
    localparam int VEC_SIDE_BIT  = 2;
    localparam int DATA_W        = 8;
    localparam int SYNC_N        = 3;
    localparam int BR_W          = 4;
    localparam logic [2:0] SEL_INPUT = 3'h0;
    localparam logic [2:0] SEL_MAINT = 3'h1;
    localparam logic [2:0] SEL_OUTPUT = 3'h2;
    localparam logic [2:0] SEL_LINE  = 3'h3;
    localparam logic [2:0] SEL_IRQ_STAT = 3'h6;
    localparam logic [2:0] SEL_IRQ_MASK = 3'h7;
    localparam int IN_RDY_BIT    = 7;
    localparam int IN_IE_BIT     = 6;
    localparam int OUT_RDY_BIT   = 7;
    localparam int OUT_IE_BIT    = 6;
    localparam int RUN_BIT       = 7;
    localparam int MCLR_BIT      = 6;
    localparam int MAINT_W       = 8;
    localparam logic [7:0] MAINT_RST = 8'h80;
    localparam logic [3:0] BR_LEVEL_FIVE = 4'h5;
    localparam logic [1:0] VSIDE_IN  = 2'h0;
    localparam logic [1:0] VSIDE_OUT = 2'h1;
    typedef enum logic [1:0] {BDI_IDLE, BDI_IN_REQ, BDI_OUT_REQ} bdi_irq_state_type;
endpackage : bdi_pkg

// >>> src/bdi_sync.sv
// Three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/100ps
module bdi_sync
    import bdi_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    dout[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule : bdi_sync

// >>> src/bdi_vec.sv
// Interrupt vector builder from switches and side bit
`timescale 1ns/100ps
module bdi_vec
    import bdi_pkg::*;
(
    input  wire logic [VEC_N-1:0] vec_sw_on,
    input  wire logic             side_out,
    output logic      [VEC_W-1:0] vector
);
    always_comb begin
        vector = '0;
        vector[VEC_HI:VEC_LO] = vec_sw_on;
        vector[VEC_SIDE_BIT]  = side_out;
    end
endmodule : bdi_vec

// >>> src/bdi_top.sv
// Host bus address decode, byte registers and two-vector interrupt logic
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/100ps
// Function
// - Open address switch needs a one
// - Closed address switch needs a zero
// - Vector bits 3-8 from six switches
// - Closed vector switch drives a one
// - Input ready with enable raises vector XX0
// - Output ready with enable raises vector XX4
// - Request at bus level five by default
// - Address bits 0-2 pick byte register
// - Vector bits 0,1 zero; bit 2 side
// - Lockout switch blocks maintenance byte clears
module bdi_top
    import bdi_pkg::*;
#(
    parameter logic [BR_W-1:0] BR_LEVEL = BR_LEVEL_FIVE
) (
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              ARST_N,
    // Configuration switches, high means closed
    input  wire logic [DEC_N-1:0]  ADDR_SW_ON,
    input  wire logic [VEC_N-1:0]  VEC_SW_ON,
    input  wire logic              RUN_INHIBIT_SWITCH,
    input  wire logic              MAINT_LOCKOUT_SWITCH,
    // Host register port
    input  wire logic [ADDR_W-1:0] HOST_ADDR,
    input  wire logic [DATA_W-1:0] HOST_WDATA,
    input  wire logic              HOST_WR,
    input  wire logic              HOST_RD,
    output logic      [DATA_W-1:0] HOST_RDATA,
    output logic                   HOST_HIT,
    // Microprocessor side ready flags
    input  wire logic              IN_READY_SET,
    input  wire logic              OUT_READY_SET,
    // Interrupt request and vector
    output logic                   IRQ_REQ,
    output logic [BR_W-1:0]        IRQ_LEVEL,
    output logic [VEC_W-1:0]       IRQ_VECTOR,
    input  wire logic              IRQ_ACK,
    output logic                   IRQ
);
    logic [DEC_N-1:0]  addr_sw;
    logic [VEC_N-1:0]  vec_sw;
    logic              run_inh;
    logic              lockout;
    logic              hit;
    logic [SEL_W-1:0]  sel;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] in_reg_ff;
    logic [DATA_W-1:0] maint_ff;
    logic [DATA_W-1:0] out_reg_ff;
    logic [DATA_W-1:0] line_ff;
    logic [1:0]        stat_ff;
    logic [1:0]        mask_ff;
    logic              in_cond;
    logic              out_cond;
    logic              in_cond_d_ff;
    logic              out_cond_d_ff;
    logic              in_pend_ff;
    logic              out_pend_ff;
    logic [VEC_W-1:0]  vec_in;
    logic [VEC_W-1:0]  vec_out;
    logic [DATA_W-1:0] nxt_rdata;
    bdi_irq_state_type state_ff;

    // Elaboration-time refusal of request levels the bus cannot carry
    if (BR_LEVEL < 4 || BR_LEVEL > 7) begin : g_bad_level
        $error("BR_LEVEL must be 4 to 7");
    end

    // Switches are asynchronous to the clock
    bdi_sync #(.WIDTH(DEC_N + VEC_N + 2)) u_sync (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .din    ({ADDR_SW_ON, VEC_SW_ON, RUN_INHIBIT_SWITCH, MAINT_LOCKOUT_SWITCH}),
        .dout   ({addr_sw, vec_sw, run_inh, lockout})
    );

    // Address compare: closed switch wants zero, open switch wants one
    assign hit = (HOST_ADDR[DEC_HI:DEC_LO] == ~addr_sw);
    assign sel = HOST_ADDR[SEL_W-1:0];
    assign wr  = HOST_WR && hit;
    assign rd  = HOST_RD && hit;

    // Input control byte
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            in_reg_ff <= '0;
        end else begin
            if (wr && sel == SEL_INPUT) begin
                in_reg_ff <= HOST_WDATA;
            end
            if (IN_READY_SET) begin
                in_reg_ff[IN_RDY_BIT] <= 1'b1;
            end
        end
    end

    // Maintenance byte; lockout holds the whole byte, so a run bit that is set stays set and a stalled unit can reboot the host
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            maint_ff <= MAINT_RST;
        end else if (wr && sel == SEL_MAINT && !lockout) begin
            maint_ff <= HOST_WDATA;
            if (run_inh) begin
                maint_ff[RUN_BIT] <= 1'b0;
            end
        end
    end

    // Output control byte
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            out_reg_ff <= '0;
        end else begin
            if (wr && sel == SEL_OUTPUT) begin
                out_reg_ff <= HOST_WDATA;
            end
            if (OUT_READY_SET) begin
                out_reg_ff[OUT_RDY_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            line_ff <= '0;
        end else if (wr && sel == SEL_LINE) begin
            line_ff <= HOST_WDATA;
        end
    end

    assign in_cond  = in_reg_ff[IN_RDY_BIT] && in_reg_ff[IN_IE_BIT];
    assign out_cond = out_reg_ff[OUT_RDY_BIT] && out_reg_ff[OUT_IE_BIT];

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            in_cond_d_ff  <= 1'b0;
            out_cond_d_ff <= 1'b0;
        end else begin
            in_cond_d_ff  <= in_cond;
            out_cond_d_ff <= out_cond;
        end
    end

    // Pending requests: a new rising condition wins over an acknowledge
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            in_pend_ff  <= 1'b0;
            out_pend_ff <= 1'b0;
        end else begin
            if (in_cond && !in_cond_d_ff) begin
                in_pend_ff <= 1'b1;
            end else if (!in_cond || (IRQ_ACK && state_ff == BDI_IN_REQ)) begin
                in_pend_ff <= 1'b0;
            end
            if (out_cond && !out_cond_d_ff) begin
                out_pend_ff <= 1'b1;
            end else if (!out_cond || (IRQ_ACK && state_ff == BDI_OUT_REQ)) begin
                out_pend_ff <= 1'b0;
            end
        end
    end

    // Request sequencer
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= BDI_IDLE;
        end else begin
            case (state_ff)
                BDI_IDLE: begin
                    if (in_pend_ff) begin
                        state_ff <= BDI_IN_REQ;
                    end else if (out_pend_ff) begin
                        state_ff <= BDI_OUT_REQ;
                    end
                end
                BDI_IN_REQ: begin
                    if (IRQ_ACK || !in_pend_ff) begin
                        state_ff <= BDI_IDLE;
                    end
                end
                BDI_OUT_REQ: begin
                    if (IRQ_ACK || !out_pend_ff) begin
                        state_ff <= BDI_IDLE;
                    end
                end
                default: state_ff <= BDI_IDLE;
            endcase
        end
    end

    bdi_vec u_vec_in (
        .vec_sw_on (vec_sw),
        .side_out  (VSIDE_IN[0]),
        .vector    (vec_in)
    );

    bdi_vec u_vec_out (
        .vec_sw_on (vec_sw),
        .side_out  (VSIDE_OUT[0]),
        .vector    (vec_out)
    );

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ_REQ    <= 1'b0;
            IRQ_VECTOR <= '0;
            IRQ_LEVEL  <= BR_LEVEL;
        end else begin
            IRQ_LEVEL <= BR_LEVEL;
            IRQ_REQ   <= (state_ff == BDI_IN_REQ && in_pend_ff && !IRQ_ACK)
                      || (state_ff == BDI_OUT_REQ && out_pend_ff && !IRQ_ACK);
            if (state_ff == BDI_OUT_REQ) begin
                IRQ_VECTOR <= vec_out;
            end else begin
                IRQ_VECTOR <= vec_in;
            end
        end
    end

    // Sticky event status, write one to clear; a new event beats the clear
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_ff <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0) ? (in_cond && !in_cond_d_ff) : (out_cond && !out_cond_d_ff)) begin
                    stat_ff[i] <= 1'b1;
                end else if (wr && sel == SEL_IRQ_STAT && HOST_WDATA[i]) begin
                    stat_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mask_ff <= '0;
        end else if (wr && sel == SEL_IRQ_MASK) begin
            mask_ff <= HOST_WDATA[1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(stat_ff & mask_ff);
        end
    end

    // Read mux, data one cycle after the strobe
    always_comb begin
        nxt_rdata = '0;
        case (sel)
            SEL_INPUT:    nxt_rdata = in_reg_ff;
            SEL_MAINT:    nxt_rdata = maint_ff;
            SEL_OUTPUT:   nxt_rdata = out_reg_ff;
            SEL_LINE:     nxt_rdata = line_ff;
            SEL_IRQ_STAT: nxt_rdata = {6'h00, stat_ff};
            SEL_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
            default:      nxt_rdata = '0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HOST_RDATA <= '0;
            HOST_HIT   <= 1'b0;
        end else begin
            HOST_RDATA <= rd ? nxt_rdata : '0;
            HOST_HIT   <= rd || wr;
        end
    end
endmodule : bdi_top

// >>> dv/bdi_chk.sv
// Port checks for the bus decode and interrupt vector block
`timescale 1ns/100ps
module bdi_chk
    import bdi_pkg::*;
#(
    parameter logic [BR_W-1:0] BR_LEVEL = BR_LEVEL_FIVE
) (
    // Clock, reset and switches
    input wire logic              SYS_CLK,
    input wire logic              ARST_N,
    input wire logic [VEC_N-1:0]  VEC_SW_ON,
    // Host register port
    input wire logic [ADDR_W-1:0] HOST_ADDR,
    input wire logic              HOST_WR,
    input wire logic              HOST_RD,
    input wire logic [DATA_W-1:0] HOST_RDATA,
    input wire logic              HOST_HIT,
    // Interrupt
    input wire logic              IRQ_REQ,
    input wire logic [BR_W-1:0]   IRQ_LEVEL,
    input wire logic [VEC_W-1:0]  IRQ_VECTOR,
    input wire logic              IRQ_ACK
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    lvl_fixed_a: assert property (IRQ_LEVEL == BR_LEVEL)
        else $error("request level differs from setting");
    vec_sw_a: assert property (IRQ_REQ |-> IRQ_VECTOR[8:3] == VEC_SW_ON)
        else $error("vector high bits differ from switches");
    vec_low_a: assert property (IRQ_REQ |-> IRQ_VECTOR[1:0] == 2'h0)
        else $error("vector low bits not zero");
    vec_hold_a: assert property (IRQ_REQ && $past(IRQ_REQ) |-> $stable(IRQ_VECTOR))
        else $error("vector moved during request");
    ack_drop_a: assert property (IRQ_REQ && IRQ_ACK |=> !IRQ_REQ)
        else $error("request held after acknowledge");
    hit_cause_a: assert property (HOST_HIT |-> $past(HOST_WR || HOST_RD))
        else $error("hit without a strobe");
    rdata_cause_a: assert property (HOST_RDATA != 8'h00 |-> HOST_HIT && $past(HOST_RD))
        else $error("read data without a decoded read");
    port_zero_a: assert property ($past(HOST_RD && HOST_ADDR[2:1] == 2'h2) |-> HOST_RDATA == 8'h00)
        else $error("data port bytes not zero");
endmodule : bdi_chk

bind bdi_top bdi_chk #(.BR_LEVEL(BR_LEVEL)) chk_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .VEC_SW_ON(VEC_SW_ON), .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD),
    .HOST_RDATA(HOST_RDATA), .HOST_HIT(HOST_HIT), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL),
    .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ACK(IRQ_ACK));

// >>> dv/bdi_host_mdl.sv
// Host processor model answering interrupt requests
`timescale 1ns/100ps
module bdi_host_mdl
    import bdi_pkg::*;
#(
    parameter int DLY = 3
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               arst_n,
    // Request side
    input  wire logic               req,
    input  wire logic [VEC_W-1:0]   vec,
    output logic                    ack,
    output logic      [1:0]         n_ack,
    output logic      [2*VEC_W-1:0] vcap
);
    logic [3:0] cnt_ff;
    // Slow answer so the vector must stand for several cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
            cnt_ff <= '0;
            n_ack <= '0;
            vcap <= '0;
        end else if (ack || !req) begin
            ack <= 1'b0;
            cnt_ff <= '0;
        end else if (cnt_ff == DLY) begin
            ack <= 1'b1;
            n_ack <= n_ack + 2'h1;
            vcap <= {vcap[VEC_W-1:0], vec};
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule : bdi_host_mdl

// >>> dv/tb_top.sv
// Self-checking bench for the bus decode and interrupt vector block
`timescale 1ns/100ps
module tb_top
    import bdi_pkg::*;
;
    localparam logic [9:0] ASW = 10'h2C5;
    localparam logic [5:0] VSW = 6'h2B;
    logic        clk = 0, rst_n = 0, rd_s = 0, wr_s = 0, ins = 0, outs = 0, lock = 0;
    logic        rinh = 0;
    logic        ack, hit, req, irq;
    logic [17:0] addr = '0, vcap;
    logic [7:0]  wd = '0, rdata;
    logic [3:0]  lvl;
    logic [8:0]  vec;
    logic [1:0]  n_ack;
    int          num_errors = 0, n_tests = 0;
    logic [18:0] rows [5] = '{{3'h3, 8'h5A, 8'h5A}, {3'h4, 8'hFF, 8'h00},
        {3'h5, 8'h33, 8'h00}, {3'h0, 8'h40, 8'h40}, {3'h2, 8'h40, 8'h40}};
    initial forever #10 clk = ~clk;
    bdi_top dut_u (.SYS_CLK(clk), .ARST_N(rst_n), .ADDR_SW_ON(ASW), .VEC_SW_ON(VSW),
        .RUN_INHIBIT_SWITCH(rinh), .MAINT_LOCKOUT_SWITCH(lock), .HOST_ADDR(addr),
        .HOST_WDATA(wd), .HOST_WR(wr_s), .HOST_RD(rd_s), .HOST_RDATA(rdata), .HOST_HIT(hit),
        .IN_READY_SET(ins), .OUT_READY_SET(outs), .IRQ_REQ(req), .IRQ_LEVEL(lvl),
        .IRQ_VECTOR(vec), .IRQ_ACK(ack), .IRQ(irq));
    bdi_host_mdl host_u (.clk(clk), .arst_n(rst_n), .req(req), .vec(vec), .ack(ack),
        .n_ack(n_ack), .vcap(vcap));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string nm);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic bad = 1'b0);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= {5'h1F, ~ASW ^ {9'h000, bad}, s};
        wd <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] s, input logic [7:0] e, input logic bad = 1'b0);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= {5'h1F, ~ASW ^ {9'h000, bad}, s};
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk({1'b0, rdata}, {1'b0, e}, "read data");
        chk({8'h00, hit}, {8'h00, ~bad}, "hit");
    endtask : rd
    task automatic results();
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk({5'h00, lvl}, {5'h00, BR_LEVEL_FIVE}, "level");
        chk({8'h00, req}, 9'h000, "request");
        rd(3'h1, MAINT_RST);
        foreach (rows[i]) begin
            wr(rows[i][18:16], rows[i][15:8]);
            rd(rows[i][18:16], rows[i][7:0]);
        end
        wr(3'h3, 8'hA5, 1'b1);
        rd(3'h3, 8'h00, 1'b1);
        rd(3'h3, 8'h5A);
        wr(3'h7, 8'h00);
        // Both sides at once, input must win
        ins <= 1'b1;
        outs <= 1'b1;
        @(posedge clk);
        ins <= 1'b0;
        outs <= 1'b0;
        for (int i = 0; i < 60 && n_ack != 2'h2; i++) @(posedge clk);
        #1;
        chk(vcap[17:9], {VSW, 3'h0}, "input vector");
        chk(vcap[8:0], {VSW, 3'h4}, "output vector");
        chk({8'h00, irq}, 9'h000, "masked irq");
        rd(3'h0, 8'hC0);
        rd(3'h6, 8'h03);
        wr(3'h7, 8'h03);
        repeat (2) @(posedge clk);
        #1 chk({8'h00, irq}, 9'h001, "irq");
        wr(3'h6, 8'h03);
        repeat (2) @(posedge clk);
        #1 chk({8'h00, irq}, 9'h000, "cleared irq");
        @(posedge clk);
        lock <= 1'b1;
        repeat (8) @(posedge clk);
        wr(3'h1, 8'h00);
        rd(3'h1, 8'h80);
        @(posedge clk);
        lock <= 1'b0;
        repeat (8) @(posedge clk);
        wr(3'h1, 8'h00);
        rd(3'h1, 8'h00);
        // Run inhibit forces the run bit low on any maintenance write made with lockout off
        @(posedge clk);
        rinh <= 1'b1;
        repeat (8) @(posedge clk);
        wr(3'h1, 8'hC0);
        rd(3'h1, 8'h40);
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule : tb_top
